// [common/pkfd_pkg.sv]
package pkfd_pkg;
	// Clock and timing
	localparam int unsigned CLK_KHZ = 50000;
	localparam int unsigned ALT_MS = 500;
	localparam int unsigned HOLD_MS = 2000;
	localparam int unsigned STEP_MS = 1000;
	localparam int unsigned ALT_CYC_DEF = ALT_MS * CLK_KHZ;
	localparam int unsigned HOLD_CYC_DEF = HOLD_MS * CLK_KHZ;
	localparam int unsigned STEP_CYC_DEF = STEP_MS * CLK_KHZ;
	localparam logic [3:0] COUNT_START = 4'ha;

	// Register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
	localparam logic [7:0] OFS_ADDR_ACT = 8'h10;
	localparam logic [7:0] OFS_ADDR_SAVED = 8'h14;

	// Status field positions
	localparam int unsigned ST_RUN = 0;
	localparam int unsigned ST_FAULT = 1;
	localparam int unsigned ST_STATE_LSB = 2;
	localparam int unsigned ST_CNT_LSB = 8;
	localparam int unsigned ST_CODE_LSB = 16;

	// Event bits
	localparam int unsigned EV_FAULT_SET = 0;
	localparam int unsigned EV_FAULT_CLR = 1;
	localparam int unsigned EV_RESTORED = 2;
	localparam int unsigned EV_RUN_CHG = 3;
	localparam int unsigned EV_W = 4;

	// Reset values
	localparam logic [31:0] FACTORY_ADDR = 32'hc0a80158;
	localparam logic [3:0] IRQ_EN_RST = 4'h0;

	// Display characters, 0x00..0x0f are hex digits
	localparam logic [4:0] CH_E = 5'h10;
	localparam logic [4:0] CH_R = 5'h11;
	localparam logic [4:0] CH_I = 5'h12;
	localparam logic [4:0] CH_P = 5'h13;
	localparam logic [4:0] CH_BLANK = 5'h1f;

	// Fault codes
	localparam logic [7:0] FC_NONE = 8'h00;
	localparam logic [7:0] FC_EXP_BUS = 8'h40;
	localparam logic [7:0] FC_EXP_CFG = 8'h41;
	localparam logic [7:0] FC_EXP_MOD = 8'h42;
	localparam logic [7:0] FC_HS_IN_ERR = 8'h60;
	localparam logic [7:0] FC_HS_IN_ALM = 8'h61;
	localparam logic [7:0] FC_HS_OUT_ERR = 8'h62;
	localparam logic [7:0] FC_HS_OUT_ALM = 8'h63;
	localparam logic [7:0] FC_FB_BUSOFF = 8'h90;
	localparam logic [7:0] FC_FB_ADDR = 8'hd1;
	localparam logic [7:0] FC_FB_NOSLAVE = 8'h95;
	localparam logic [7:0] FC_FB_ALLGONE = 8'h43;
	localparam logic [7:0] FC_FB_FRAME = 8'h84;

	typedef enum logic [2:0] {
		RS_IDLE = 3'b000,
		RS_HOLD = 3'b001,
		RS_PROMPT = 3'b010,
		RS_COUNT = 3'b011,
		RS_FINAL = 3'b100
	} pkfd_rst_e;
endpackage : pkfd_pkg

// [rtl/pkfd_sync.sv]
`timescale 1ns/100ps
module pkfd_sync #(
	parameter int unsigned W = 2
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] rst_val_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire [W-1:0] agree = ~(s2 ^ s3);
	wire [W-1:0] next_sync = (agree & s2) | (~agree & sync_o);

	// Reset value is a constant tie-off at the instance
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s1 <= rst_val_i;
			s2 <= rst_val_i;
			s3 <= rst_val_i;
			sync_o <= rst_val_i;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			sync_o <= next_sync;
		end
	end
endmodule : pkfd_sync

// [rtl/pkfd_panel.sv]
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
module pkfd_panel import pkfd_pkg::*; #(
	parameter int unsigned ALT_CYC = ALT_CYC_DEF,
	parameter int unsigned HOLD_CYC = HOLD_CYC_DEF,
	parameter int unsigned STEP_CYC = STEP_CYC_DEF
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic key_n_i,
	input wire logic run_i,
	input wire logic [2:0] exp_fault_i,
	input wire logic [3:0] hsio_fault_i,
	input wire logic [4:0] fbus_fault_i,
	input wire logic fbus_master_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o,
	output logic run_lamp_o,
	output logic err_lamp_o,
	output logic expansion_fault_lamp_o,
	output logic link_fault_lamp_o,
	output logic [4:0] disp_hi_o,
	output logic [4:0] disp_lo_o,
	output logic [1:0] disp_dp_o,
	output logic [31:0] net_addr_o
);
	function automatic logic [7:0] fault_code_f(input logic [2:0] ex, input logic [3:0] hs,
			input logic [4:0] fb, input logic master);
		logic [7:0] c;
		c = FC_NONE;
		if (ex[0]) c = FC_EXP_BUS;
		else if (ex[1]) c = FC_EXP_CFG;
		else if (ex[2]) c = FC_EXP_MOD;
		else if (hs[0]) c = FC_HS_IN_ERR;
		else if (hs[1]) c = FC_HS_IN_ALM;
		else if (hs[2]) c = FC_HS_OUT_ERR;
		else if (hs[3]) c = FC_HS_OUT_ALM;
		else if (fb[0]) c = FC_FB_BUSOFF;
		else if (fb[1]) c = FC_FB_ADDR;
		else if (fb[2]) c = FC_FB_NOSLAVE;
		else if (fb[3] && master) c = FC_FB_ALLGONE;
		else if (fb[4]) c = FC_FB_FRAME;
		return c;
	endfunction : fault_code_f

	function automatic logic [4:0] nib_ch_f(input logic [3:0] n);
		return {1'b0, n};
	endfunction : nib_ch_f

	logic key_s;
	logic run_s;
	logic key_prev;
	pkfd_rst_e rs_state;
	logic [31:0] tmr;
	logic [3:0] cnt;
	logic [31:0] alt_tmr;
	logic alt_phase;
	logic fault_q;
	logic run_q;
	logic [EV_W-1:0] irq_stat;
	logic [EV_W-1:0] irq_en;
	logic [31:0] addr_saved;
	pkfd_rst_e next_state;
	logic [31:0] next_tmr;
	logic [3:0] next_cnt;

	// Key pin is low while pressed; idle high after reset
	pkfd_sync #(.W(2)) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.rst_val_i(2'b01),
		.pin_i({run_i, key_n_i}),
		.sync_o({run_s, key_s})
	);

	wire key_down = ~key_s;
	wire key_edge = key_down & ~key_prev;
	wire fb_eff_3 = fbus_fault_i[3] & fbus_master_i;
	wire exp_any = |exp_fault_i;
	wire fb_any = fbus_fault_i[0] | fbus_fault_i[1] | fbus_fault_i[2] | fb_eff_3 | fbus_fault_i[4];
	wire any_fault = exp_any | (|hsio_fault_i) | fb_any;
	wire [7:0] fault_code = fault_code_f(exp_fault_i, hsio_fault_i, fbus_fault_i, fbus_master_i);
	wire tmr_hold_done = tmr == HOLD_CYC - 1;
	wire tmr_step_done = tmr == STEP_CYC - 1;
	wire alt_done = alt_tmr == ALT_CYC - 1;
	wire restore_ev = (rs_state == RS_FINAL) && key_edge && !run_s;

	// Restore sequence
	always_comb begin
		next_state = rs_state;
		next_tmr = tmr + 32'h1;
		next_cnt = cnt;
		unique case (rs_state)
			RS_IDLE: begin
				next_tmr = 32'h0;
				if (key_down && !run_s) next_state = RS_HOLD;
			end
			RS_HOLD: begin
				if (!key_down) next_state = RS_IDLE;
				else if (tmr_hold_done) next_state = RS_PROMPT;
			end
			RS_PROMPT: begin
				next_tmr = 32'h0;
				if (key_edge) begin
					next_state = RS_COUNT;
					next_cnt = COUNT_START;
				end
			end
			RS_COUNT: begin
				if (tmr_step_done) begin
					next_tmr = 32'h0;
					next_cnt = cnt - 4'h1;
					if (cnt == 4'h1) next_state = RS_FINAL;
				end
			end
			RS_FINAL: begin
				next_tmr = 32'h0;
				if (key_edge) next_state = RS_IDLE;
			end
			default: next_state = RS_IDLE;
		endcase
		if (run_s) begin
			next_state = RS_IDLE;
			next_tmr = 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rs_state <= RS_IDLE;
			tmr <= 32'h0;
			cnt <= 4'h0;
			key_prev <= 1'b0;
		end else begin
			rs_state <= next_state;
			tmr <= next_tmr;
			cnt <= next_cnt;
			key_prev <= key_down;
		end
	end

	// Alternation phase runs only while a fault is present
	wire [31:0] next_alt_tmr = (!any_fault || alt_done) ? 32'h0 : alt_tmr + 32'h1;
	wire next_alt_phase = !any_fault ? 1'b0 : (alt_done ? ~alt_phase : alt_phase);

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			alt_tmr <= 32'h0;
			alt_phase <= 1'b0;
		end else begin
			alt_tmr <= next_alt_tmr;
			alt_phase <= next_alt_phase;
		end
	end

	// Display selection, restore sequence takes precedence
	wire show_prompt = (rs_state == RS_PROMPT);
	wire show_count = (rs_state == RS_COUNT) || (rs_state == RS_FINAL);
	wire show_prefix = any_fault && !alt_phase;
	wire [4:0] cnt_hi = (cnt >= COUNT_START) ? 5'h01 : 5'h00;
	wire [4:0] cnt_lo = (cnt >= COUNT_START) ? 5'h00 : nib_ch_f(cnt);
	wire [4:0] next_hi = show_prompt ? CH_I : show_count ? cnt_hi :
		show_prefix ? CH_E : nib_ch_f(fault_code[7:4]);
	wire [4:0] next_lo = show_prompt ? CH_P : show_count ? cnt_lo :
		show_prefix ? CH_R : nib_ch_f(fault_code[3:0]);
	wire [1:0] next_dp = (show_prompt || (!show_count && show_prefix)) ? 2'b11 : 2'b00;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			disp_hi_o <= 5'h00;
			disp_lo_o <= 5'h00;
			disp_dp_o <= 2'b00;
			run_lamp_o <= 1'b0;
			err_lamp_o <= 1'b0;
			expansion_fault_lamp_o <= 1'b0;
			link_fault_lamp_o <= 1'b0;
		end else begin
			disp_hi_o <= next_hi;
			disp_lo_o <= next_lo;
			disp_dp_o <= next_dp;
			run_lamp_o <= run_s;
			err_lamp_o <= any_fault;
			expansion_fault_lamp_o <= exp_any;
			link_fault_lamp_o <= fb_any;
		end
	end

	// Register decode
	wire wr_clr = reg_wr_i && (reg_addr_i == OFS_IRQ_CLR);
	wire wr_en = reg_wr_i && (reg_addr_i == OFS_IRQ_EN);
	wire wr_saved = reg_wr_i && (reg_addr_i == OFS_ADDR_SAVED);
	wire [EV_W-1:0] ev;
	assign ev[EV_FAULT_SET] = any_fault && !fault_q;
	assign ev[EV_FAULT_CLR] = !any_fault && fault_q;
	assign ev[EV_RESTORED] = restore_ev;
	assign ev[EV_RUN_CHG] = run_s ^ run_q;
	wire [EV_W-1:0] clr_mask = wr_clr ? reg_wdata_i[EV_W-1:0] : '0;
	wire [EV_W-1:0] next_irq_stat = (irq_stat & ~clr_mask) | ev;
	wire [31:0] status_word = {8'h00, fault_code, 4'h0, cnt, 3'b000, rs_state, any_fault, run_s};
	wire [31:0] rd_mux =
		(reg_addr_i == OFS_STATUS) ? status_word :
		(reg_addr_i == OFS_IRQ_STAT) ? {28'h0, irq_stat} :
		(reg_addr_i == OFS_IRQ_EN) ? {28'h0, irq_en} :
		(reg_addr_i == OFS_ADDR_ACT) ? net_addr_o :
		(reg_addr_i == OFS_ADDR_SAVED) ? addr_saved : 32'h0;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			irq_stat <= '0;
			irq_en <= IRQ_EN_RST;
			fault_q <= 1'b0;
			run_q <= 1'b0;
			irq_o <= 1'b0;
			reg_rdata_o <= 32'h0;
		end else begin
			irq_stat <= next_irq_stat;
			if (wr_en) irq_en <= reg_wdata_i[EV_W-1:0];
			fault_q <= any_fault;
			run_q <= run_s;
			irq_o <= |(next_irq_stat & irq_en);
			reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
		end
	end

	// Saved address never reaches net_addr_o; reset loads FACTORY_ADDR into both
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			addr_saved <= FACTORY_ADDR;
			net_addr_o <= FACTORY_ADDR;
		end else begin
			if (restore_ev) addr_saved <= FACTORY_ADDR;
			else if (wr_saved) addr_saved <= reg_wdata_i;
			net_addr_o <= net_addr_o;
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	run_lamp_a: assert property (run_s ##1 run_s |-> run_lamp_o) else $error("run lamp off");
	err_lamp_a: assert property (any_fault |=> err_lamp_o) else $error("err lamp off");
	link_lamp_a: assert property (fb_any |=> link_fault_lamp_o && !$past(exp_any) == !expansion_fault_lamp_o)
		else $error("fault lamps wrong");
	key_stop_a: assert property (run_s |=> rs_state == RS_IDLE) else $error("key acted while running");
	addr_value_a: assert property (restore_ev |=> addr_saved == FACTORY_ADDR)
		else $error("factory address not stored");
	prompt_show_a: assert property (rs_state == RS_PROMPT |=> disp_hi_o == CH_I && disp_lo_o == CH_P)
		else $error("prompt not shown");
	count_start_a: assert property (rs_state == RS_PROMPT && key_edge && !run_s
		|=> rs_state == RS_COUNT && cnt == COUNT_START ##1 disp_hi_o == 5'h01)
		else $error("countdown did not start at 10");
	no_early_a: assert property (rs_state == RS_COUNT && !wr_saved |=> $stable(addr_saved))
		else $error("address changed before countdown end");
	addr_hold_a: assert property ($stable(net_addr_o)) else $error("active address moved");
	alt_show_a: assert property (any_fault && !alt_phase && rs_state == RS_IDLE
		|=> disp_hi_o == CH_E && disp_lo_o == CH_R && disp_dp_o == 2'b11)
		else $error("error prefix missing");
	code_exp_a: assert property (exp_fault_i == 3'b010 |-> fault_code == FC_EXP_CFG)
		else $error("expansion code wrong");
	code_hsio_a: assert property (!exp_any && hsio_fault_i == 4'b1000 |-> fault_code == FC_HS_OUT_ALM)
		else $error("high-speed code wrong");
	code_fbus_a: assert property (!exp_any && hsio_fault_i == 4'h0 && fbus_fault_i == 5'b00010
		|-> fault_code == FC_FB_ADDR) else $error("fieldbus code wrong");
	code_lost_a: assert property (!exp_any && hsio_fault_i == 4'h0 && fbus_fault_i == 5'b01000
		|-> fault_code == (fbus_master_i ? FC_FB_ALLGONE : FC_NONE))
		else $error("all slaves lost code wrong");
	abort_seq_a: assert property (rs_state != RS_IDLE && run_s |=> rs_state == RS_IDLE && $stable(net_addr_o))
		else $error("restore not abandoned");
	idle_zero_a: assert property (!any_fault && rs_state == RS_IDLE
		|=> disp_hi_o == 5'h00 && disp_lo_o == 5'h00 && disp_dp_o == 2'b00)
		else $error("idle display not 00");

	prompt_c: cover property (rs_state == RS_HOLD ##1 rs_state == RS_PROMPT);
	restore_c: cover property (restore_ev);
	fault_alt_c: cover property (any_fault && alt_done);
	irq_c: cover property ($rose(irq_o));
endmodule : pkfd_panel

// [sim/pkfd_operator.sv]
`timescale 1ns/100ps
module pkfd_operator (
	input wire logic clk_i,
	input wire logic press_i,
	output logic key_n_o
);
	// Key contact pulls the pin low while pressed, pull-up otherwise
	always_ff @(posedge clk_i) begin
		key_n_o <= ~press_i;
	end
endmodule : pkfd_operator

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench import pkfd_pkg::*;;
	typedef struct packed {
		logic [2:0] e;
		logic [3:0] h;
		logic [4:0] f;
		logic [7:0] code;
	} pkfd_tbrow_s;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic press = 1'b0;
	logic key_n;
	logic run_i = 1'b0;
	logic [2:0] exp_f = 3'h0;
	logic [3:0] hs_f = 4'h0;
	logic [4:0] fb_f = 5'h00;
	logic master = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata, net, rv;
	logic irq, run_l, err_l, exp_l, lnk_l;
	logic [4:0] dhi, dlo;
	logic [1:0] dp;
	int err_count = 0;
	int n_checks = 0;
	pkfd_tbrow_s rows [12] = '{'{3'h1, 4'h0, 5'h00, 8'h40}, '{3'h2, 4'h0, 5'h00, 8'h41},
		'{3'h4, 4'h0, 5'h00, 8'h42}, '{3'h0, 4'h1, 5'h00, 8'h60}, '{3'h0, 4'h2, 5'h00, 8'h61},
		'{3'h0, 4'h4, 5'h00, 8'h62}, '{3'h0, 4'h8, 5'h00, 8'h63}, '{3'h0, 4'h0, 5'h01, 8'h90},
		'{3'h0, 4'h0, 5'h02, 8'hd1}, '{3'h0, 4'h0, 5'h04, 8'h95}, '{3'h0, 4'h0, 5'h08, 8'h43},
		'{3'h0, 4'h0, 5'h10, 8'h84}};

	always #10 clk_i = ~clk_i;

	pkfd_operator op_u (.clk_i(clk_i), .press_i(press), .key_n_o(key_n));

	pkfd_panel #(.ALT_CYC(8), .HOLD_CYC(16), .STEP_CYC(8)) dut_u (
		.clk_i(clk_i), .nrst_i(nrst_i), .key_n_i(key_n), .run_i(run_i),
		.exp_fault_i(exp_f), .hsio_fault_i(hs_f), .fbus_fault_i(fb_f), .fbus_master_i(master),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .irq_o(irq), .run_lamp_o(run_l), .err_lamp_o(err_l),
		.expansion_fault_lamp_o(exp_l), .link_fault_lamp_o(lnk_l),
		.disp_hi_o(dhi), .disp_lo_o(dlo), .disp_dp_o(dp), .net_addr_o(net)
	);

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] got, input logic [31:0] want);
		n_checks++;
		if (got !== want) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, want);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		// Read data stand in the cycle after the strobe; take them at its closing edge
		@(posedge clk_i);
		d = rdata;
	endtask : reg_rd

	// Bounded wait for a character pair on the display
	task automatic wait_disp(input logic [4:0] h, input logic [4:0] l, input int lim);
		for (int i = 0; i < lim && !(dhi === h && dlo === l); i++) @(posedge clk_i);
		check(32'({dhi, dlo}), 32'({h, l}));
	endtask : wait_disp

	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		cyc(4);
		reg_rd(OFS_IRQ_EN, rv);
		check(rv, 32'h0);
		reg_rd(OFS_ADDR_SAVED, rv);
		check(rv, 32'hc0a80158);
		reg_wr(OFS_ADDR_ACT, 32'h0);
		reg_rd(OFS_ADDR_ACT, rv);
		check(rv, 32'hc0a80158);
		reg_rd(8'h40, rv);
		check(rv, 32'h0);
		check(32'({dhi, dlo, dp, err_l}), 32'h0);
		$display("test reset and map done");
		for (int k = 0; k < 12; k++) begin
			exp_f <= rows[k].e;
			hs_f <= rows[k].h;
			fb_f <= rows[k].f;
			cyc(6);
			reg_rd(OFS_STATUS, rv);
			check(32'(rv[23:16]), 32'(rows[k].code));
			check(32'({err_l, exp_l, lnk_l}), 32'({1'b1, |rows[k].e, |rows[k].f}));
			wait_disp(CH_E, CH_R, 40);
			wait_disp({1'b0, rows[k].code[7:4]}, {1'b0, rows[k].code[3:0]}, 40);
			$display("test fault row %0d done", k);
		end
		master <= 1'b0;
		fb_f <= 5'h08;
		cyc(6);
		reg_rd(OFS_STATUS, rv);
		check(32'({rv[23:16], err_l}), 32'h0);
		fb_f <= 5'h00;
		wait_disp(5'h00, 5'h00, 40);
		check(32'(dp), 32'h0);
		$display("test no fault done");
		reg_wr(OFS_IRQ_CLR, 32'hf);
		run_i <= 1'b1;
		cyc(8);
		check(32'(run_l), 32'h1);
		reg_rd(OFS_IRQ_STAT, rv);
		check(32'({rv[3], irq}), 32'h2);
		reg_wr(OFS_IRQ_EN, 32'h8);
		cyc(2);
		check(32'(irq), 32'h1);
		reg_wr(OFS_IRQ_CLR, 32'h8);
		cyc(2);
		check(32'(irq), 32'h0);
		press <= 1'b1;
		cyc(40);
		reg_rd(OFS_STATUS, rv);
		check(32'(rv[4:2]), 32'h0);
		press <= 1'b0;
		run_i <= 1'b0;
		cyc(8);
		check(32'(run_l), 32'h0);
		$display("test run and irq done");
		reg_wr(OFS_ADDR_SAVED, 32'h0a000001);
		press <= 1'b1;
		wait_disp(CH_I, CH_P, 40);
		check(32'(dp), 32'h3);
		run_i <= 1'b1;
		cyc(8);
		reg_rd(OFS_STATUS, rv);
		check(32'(rv[4:2]), 32'h0);
		run_i <= 1'b0;
		press <= 1'b0;
		cyc(8);
		reg_rd(OFS_ADDR_SAVED, rv);
		check(rv, 32'h0a000001);
		$display("test abandon done");
		press <= 1'b1;
		wait_disp(CH_I, CH_P, 40);
		press <= 1'b0;
		cyc(6);
		press <= 1'b1;
		wait_disp(5'h01, 5'h00, 20);
		wait_disp(5'h00, 5'h09, 12);
		press <= 1'b0;
		cyc(4);
		press <= 1'b1;
		cyc(6);
		press <= 1'b0;
		wait_disp(5'h00, 5'h00, 100);
		reg_rd(OFS_STATUS, rv);
		check(32'(rv[4:2]), 32'h4);
		reg_rd(OFS_ADDR_SAVED, rv);
		check(rv, 32'h0a000001);
		reg_wr(OFS_IRQ_CLR, 32'hf);
		press <= 1'b1;
		cyc(8);
		press <= 1'b0;
		reg_rd(OFS_ADDR_SAVED, rv);
		check(rv, 32'hc0a80158);
		reg_rd(OFS_IRQ_STAT, rv);
		check(32'(rv[2]), 32'h1);
		check(net, 32'hc0a80158);
		$display("test restore done");
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		print_verdict();
	end
endmodule : testbench
